// ---- wire_master_cfg.sv ----
// Settings, status and pullup control of the single-wire bus master.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Read pointer selects settings, status, read data.
// - Settings read zero after rstn_in reset or device reset.
// - Write accepted only if nibbles complement.
// - Settings high nibble always reads zero.
// - Bits: slew pullup, zero, boost, speed.
// - Boost enable self-clears when boost ends.
// - Slew pullup drives rising edge for on-time.
// - No slew pullup on presence or short recovery.
// - Boost starts at slot edge, ends on events.
// - External gate low exactly while boost active.
// - Boost leaves slew pullup enable untouched.
// - Speed bit selects standard or overdrive timing.
// - Status bit order dir down to busy.
// - Bus commands and device reset point status.
// - Busy flag high while bus traffic runs.
// - Presence sampled per bus reset, zero if short.
// - Short sampled per bus reset, clears when gone.
// - Pullup on-time 2.5 or 0.5 microseconds.
// - Short sample point 8 or 0.75 microseconds.
// - Device reset clears speed, slew, boost bits.
module wire_master_cfg
  import wire_master_pkg::*;
#(
  parameter int RST_LOW_STD  = RST_LOW_STD_CYC,
  parameter int RST_HIGH_STD = RST_HIGH_STD_CYC
) (
  // Clock and asynchronous reset.
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // Decoded function commands, one-cycle strobes.
  input  wire logic       cmd_dev_reset_in,
  input  wire logic       cmd_set_ptr_in,
  input  wire logic       cmd_write_cfg_in,
  input  wire logic       cmd_bus_reset_in,
  input  wire logic       cmd_slot_in,
  input  wire logic [1:0] cmd_slot_op_in,
  input  wire logic [7:0] cmd_arg_in,
  // Host read of the selected register.
  input  wire logic       rd_strobe_in,
  output logic [7:0]      rd_data_out,
  output logic            cmd_refused_out,
  // External slot sequencer.
  output logic            seq_start_out,
  output logic [1:0]      seq_op_out,
  output logic [7:0]      seq_arg_out,
  output logic            seq_abort_out,
  output logic            fast_speed_select_out,
  input  wire logic       seq_busy_in,
  input  wire logic       seq_last_slot_in,
  input  wire logic       seq_done_in,
  input  wire logic       seq_single_in,
  input  wire logic       seq_second_in,
  input  wire logic       seq_dir_in,
  input  wire logic [7:0] seq_byte_in,
  // Single-wire line.
  input  wire logic       line_in,
  output logic            line_low_out,
  output logic            pullup_on_out,
  output logic            ext_boost_gate_n_out
);

  // Refuse counts that overflow the counter, a zero low count, or a high count not past the presence sample point.
  initial begin
    if (RST_LOW_STD < 1 || RST_LOW_STD >= (1 << CNT_W) ||
        RST_HIGH_STD <= PRES_SMP_STD_CYC ||
        RST_HIGH_STD >= (1 << CNT_W)) begin
      $error("wire_master_cfg: reset cycle counts out of range");
    end
  end

  logic             rst_meta_ff;
  logic             rstn_sync_ff;
  logic             line_s;
  logic             line_d_ff;
  logic             line_rise;
  logic             slew_pullup_enable_ff;
  logic             boost_pullup_enable_ff;
  logic             fast_speed_select_ff;
  logic             boost_active_ff;
  logic             boost_slot_ff;
  logic             line_busy_flag;
  logic             presence_seen_ff;
  logic             short_seen_ff;
  logic             line_level_ff;
  logic             reset_seen_ff;
  logic             single_slot_result_ff;
  logic             second_slot_result_ff;
  logic             branch_dir_ff;
  logic [7:0]       read_data_ff;
  logic [7:0]       status_byte;
  logic [7:0]       cfg_byte;
  logic [1:0]       seq_op_ff;
  logic             cfg_ok;
  logic             cfg_take;
  logic             comm_take;
  logic             ptr_ok;
  logic             slew_start;
  logic             timer_on;
  logic [CNT_W-1:0] pullup_on_time;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] low_len;
  logic [CNT_W-1:0] high_len;
  logic [CNT_W-1:0] short_pt;
  logic [CNT_W-1:0] presence_sample_point;
  read_ptr_e        ptr_ff;
  reset_cycle_e     rc_ff;
  reset_cycle_e     nxt_rc;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_ff  <= 1'b0;
      rstn_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff  <= 1'b1;
      rstn_sync_ff <= rst_meta_ff;
    end
  end

  // The line pin is asynchronous, so it is synchronised before use.
  line_sync #(
    .WIDTH (1)
  ) u_line_sync (
    .clk_in   (sys_clk_in),
    .rstn_in  (rstn_sync_ff),
    .async_in (line_in),
    .sync_out (line_s)
  );

  // Rising-edge detector on the synchronised line.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      line_d_ff <= 1'b1;
    end else begin
      line_d_ff <= line_s;
    end
  end
  assign line_rise = line_s & ~line_d_ff;

  // Speed-dependent counts; the speed bit times all traffic.
  assign pullup_on_time = fast_speed_select_ff ?
    CNT_W'(PULLUP_ON_FAST_CYC) : CNT_W'(PULLUP_ON_STD_CYC);
  assign short_pt = fast_speed_select_ff ?
    CNT_W'(SHORT_SMP_FAST_CYC) : CNT_W'(SHORT_SMP_STD_CYC);
  assign presence_sample_point = fast_speed_select_ff ?
    CNT_W'(PRES_SMP_FAST_CYC) : CNT_W'(PRES_SMP_STD_CYC);
  assign low_len = fast_speed_select_ff ?
    CNT_W'(RST_LOW_FAST_CYC) : CNT_W'(RST_LOW_STD);
  assign high_len = fast_speed_select_ff ?
    CNT_W'(RST_HIGH_FAST_CYC) : CNT_W'(RST_HIGH_STD);

  // Command acceptance; bus commands and settings are refused while the line is busy.
  assign line_busy_flag = (rc_ff != RC_IDLE) | seq_busy_in;
  assign cfg_ok    = (cmd_arg_in[7:4] == ~cmd_arg_in[3:0]);
  assign cfg_take  = cmd_write_cfg_in & ~line_busy_flag & ~cmd_dev_reset_in;
  assign comm_take = (cmd_bus_reset_in | cmd_slot_in) & ~line_busy_flag &
                     ~cmd_dev_reset_in;
  assign ptr_ok    = (cmd_arg_in == PTR_CODE_STATUS) |
                     (cmd_arg_in == PTR_CODE_DATA) |
                     (cmd_arg_in == PTR_CODE_CONFIG);
  assign cmd_refused_out = ((cmd_write_cfg_in | cmd_bus_reset_in |
                             cmd_slot_in) & line_busy_flag) |
                           (cmd_set_ptr_in & ~ptr_ok);

  // Read pointer follows the last executed command.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      ptr_ff <= PTR_STATUS;
    end else if (cmd_dev_reset_in || comm_take) begin
      ptr_ff <= PTR_STATUS;
    end else if (cfg_take) begin
      ptr_ff <= PTR_CONFIG;
    end else if (cmd_set_ptr_in && ptr_ok) begin
      case (cmd_arg_in)
        PTR_CODE_DATA:   ptr_ff <= PTR_DATA;
        PTR_CODE_CONFIG: ptr_ff <= PTR_CONFIG;
        default:         ptr_ff <= PTR_STATUS;
      endcase
    end
  end

  // Speed and slew pullup hold until rewritten or reset.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      slew_pullup_enable_ff <= CFG_RESET[CFG_SLEW_BIT];
      fast_speed_select_ff  <= CFG_RESET[CFG_FAST_BIT];
    end else if (cmd_dev_reset_in) begin
      slew_pullup_enable_ff <= CFG_RESET[CFG_SLEW_BIT];
      fast_speed_select_ff  <= CFG_RESET[CFG_FAST_BIT];
    end else if (cfg_take && cfg_ok) begin
      slew_pullup_enable_ff <= cmd_arg_in[CFG_SLEW_BIT];
      fast_speed_select_ff  <= cmd_arg_in[CFG_FAST_BIT];
    end
  end

  // Boost enable clears itself when the boost ends; the slew pullup
  // enable is never touched here.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      boost_pullup_enable_ff <= CFG_RESET[CFG_BOOST_BIT];
    end else if (cmd_dev_reset_in) begin
      boost_pullup_enable_ff <= CFG_RESET[CFG_BOOST_BIT];
    end else if (cfg_take && cfg_ok) begin
      boost_pullup_enable_ff <= cmd_arg_in[CFG_BOOST_BIT];
    end else if (boost_active_ff && comm_take) begin
      boost_pullup_enable_ff <= 1'b0;
    end
  end

  // Remembers that the running slot command may end in a boost.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      boost_slot_ff <= 1'b0;
    end else if (cmd_dev_reset_in) begin
      boost_slot_ff <= 1'b0;
    end else if (comm_take) begin
      boost_slot_ff <= cmd_slot_in & boost_pullup_enable_ff &
                       ((cmd_slot_op_in == OP_WRITE_BYTE) |
                        (cmd_slot_op_in == OP_SINGLE_BIT));
    end else if (boost_active_ff) begin
      boost_slot_ff <= 1'b0;
    end
  end

  // Boost starts on the last slot's rising edge and holds the
  // transistor on until a bus command, a disabling write or a reset.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      boost_active_ff <= 1'b0;
    end else if (cmd_dev_reset_in || comm_take) begin
      boost_active_ff <= 1'b0;
    end else if (cfg_take && cfg_ok && !cmd_arg_in[CFG_BOOST_BIT]) begin
      boost_active_ff <= 1'b0;
    end else if (boost_slot_ff && seq_last_slot_in && line_rise &&
                 boost_pullup_enable_ff) begin
      boost_active_ff <= 1'b1;
    end
  end

  // Slew pullup fires on a rising edge, the bus reset release included,
  // but not at the end of presence or after a short.
  assign slew_start = line_rise & slew_pullup_enable_ff & ~boost_active_ff &
                      ~(short_seen_ff & (rc_ff != RC_HIGH)) &
                      ((rc_ff != RC_HIGH) | (cnt_ff < short_pt));

  pullup_timer #(
    .W (CNT_W)
  ) u_pullup_timer (
    .clk_in     (sys_clk_in),
    .rstn_in    (rstn_sync_ff),
    .start_in   (slew_start),
    .len_in     (pullup_on_time),
    .abort_in   (cmd_dev_reset_in),
    .active_out (timer_on)
  );

  // Pin drivers; the gate follows the boost flag exactly.
  assign pullup_on_out         = timer_on | boost_active_ff;
  assign ext_boost_gate_n_out  = ~boost_active_ff;
  assign line_low_out          = (rc_ff == RC_LOW);
  assign fast_speed_select_out = fast_speed_select_ff;

  // Bus reset cycle: drive low, then release and sample.
  always_comb begin
    nxt_rc = rc_ff;
    case (rc_ff)
      RC_IDLE: if (comm_take && cmd_bus_reset_in) nxt_rc = RC_LOW;
      RC_LOW:  if (cnt_ff == low_len - CNT_W'(1)) nxt_rc = RC_HIGH;
      RC_HIGH: if (cnt_ff == high_len - CNT_W'(1)) nxt_rc = RC_IDLE;
      default: nxt_rc = RC_IDLE;
    endcase
    if (cmd_dev_reset_in) begin
      nxt_rc = RC_IDLE;
    end
  end

  // Phase state and the cycle counter inside each phase.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      rc_ff  <= RC_IDLE;
      cnt_ff <= '0;
    end else begin
      rc_ff  <= nxt_rc;
      cnt_ff <= (nxt_rc != rc_ff || rc_ff == RC_IDLE) ? '0 :
                cnt_ff + CNT_W'(1);
    end
  end

  // Short and presence samples; presence stays zero while shorted.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      short_seen_ff    <= 1'b0;
      presence_seen_ff <= 1'b0;
    end else if (cmd_dev_reset_in) begin
      short_seen_ff    <= 1'b0;
      presence_seen_ff <= 1'b0;
    end else if (rc_ff == RC_HIGH && cnt_ff == short_pt) begin
      short_seen_ff    <= ~line_s;
      presence_seen_ff <= 1'b0;
    end else if (rc_ff == RC_HIGH && cnt_ff == presence_sample_point) begin
      presence_seen_ff <= ~line_s & ~short_seen_ff;
    end
  end

  // Reset marker, sequencer results and the read data byte.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      reset_seen_ff         <= RST_SEEN_RESET;
      single_slot_result_ff <= 1'b0;
      second_slot_result_ff <= 1'b0;
      branch_dir_ff         <= 1'b0;
      read_data_ff          <= 8'h00;
    end else if (cmd_dev_reset_in) begin
      reset_seen_ff         <= RST_SEEN_RESET;
      single_slot_result_ff <= 1'b0;
      second_slot_result_ff <= 1'b0;
      branch_dir_ff         <= 1'b0;
    end else begin
      if (cfg_take) begin
        reset_seen_ff <= 1'b0;
      end
      if (seq_done_in) begin
        case (seq_op_ff)
          OP_SINGLE_BIT: single_slot_result_ff <= seq_single_in;
          OP_READ_BYTE:  read_data_ff <= seq_byte_in;
          OP_TRIPLET: begin
            single_slot_result_ff <= seq_single_in;
            second_slot_result_ff <= seq_second_in;
            branch_dir_ff         <= seq_dir_in;
          end
          default: read_data_ff <= read_data_ff;
        endcase
      end
    end
  end

  // Line level is sampled only by a read aimed at the status byte.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      line_level_ff <= 1'b0;
    end else if (rd_strobe_in && ptr_ff == PTR_STATUS) begin
      line_level_ff <= line_s;
    end
  end

  // Sequencer launch, registered so data outputs come from flip-flops.
  always_ff @(posedge sys_clk_in or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      seq_start_out <= 1'b0;
      seq_abort_out <= 1'b0;
      seq_op_ff     <= OP_SINGLE_BIT;
      seq_arg_out   <= 8'h00;
    end else begin
      seq_start_out <= comm_take & cmd_slot_in;
      seq_abort_out <= cmd_dev_reset_in;
      if (comm_take && cmd_slot_in) begin
        seq_op_ff   <= cmd_slot_op_in;
        seq_arg_out <= cmd_arg_in;
      end
    end
  end
  assign seq_op_out = seq_op_ff;

  // Status and settings images.
  assign status_byte = {branch_dir_ff, second_slot_result_ff,
                        single_slot_result_ff, reset_seen_ff,
                        line_level_ff, short_seen_ff, presence_seen_ff,
                        line_busy_flag};
  always_comb begin
    cfg_byte = 8'h00;
    cfg_byte[CFG_SLEW_BIT]  = slew_pullup_enable_ff;
    cfg_byte[CFG_ZERO_BIT]  = 1'b0;
    cfg_byte[CFG_BOOST_BIT] = boost_pullup_enable_ff;
    cfg_byte[CFG_FAST_BIT]  = fast_speed_select_ff;
  end

  // Read mux driven by the pointer.
  always_comb begin
    case (ptr_ff)
      PTR_CONFIG: rd_data_out = cfg_byte;
      PTR_DATA:   rd_data_out = read_data_ff;
      default:    rd_data_out = status_byte;
    endcase
  end

endmodule
`default_nettype wire

// ---- wire_master_pkg.sv ----
// Shared constants and types for the single-wire master settings block.
package wire_master_pkg;

  // Clock period of sys_clk_in in nanoseconds.
  localparam int CLK_PERIOD_NS = 25;

  // Line timing in nanoseconds, standard and overdrive speed.
  localparam int PULLUP_ON_STD_NS  = 2500;
  localparam int PULLUP_ON_FAST_NS = 500;
  localparam int SHORT_SMP_STD_NS  = 8000;
  localparam int SHORT_SMP_FAST_NS = 750;
  localparam int PRES_SMP_STD_NS   = 70000;
  localparam int PRES_SMP_FAST_NS  = 7500;
  localparam int RST_LOW_STD_NS    = 600000;
  localparam int RST_LOW_FAST_NS   = 72000;
  localparam int RST_HIGH_STD_NS   = 584000;
  localparam int RST_HIGH_FAST_NS  = 74000;

  // Cycle counts derived from the times; nominal figures divide exactly.
  localparam int PULLUP_ON_STD_CYC  = PULLUP_ON_STD_NS / CLK_PERIOD_NS;
  localparam int PULLUP_ON_FAST_CYC = PULLUP_ON_FAST_NS / CLK_PERIOD_NS;
  localparam int SHORT_SMP_STD_CYC  = SHORT_SMP_STD_NS / CLK_PERIOD_NS;
  localparam int SHORT_SMP_FAST_CYC = SHORT_SMP_FAST_NS / CLK_PERIOD_NS;
  localparam int PRES_SMP_STD_CYC   = PRES_SMP_STD_NS / CLK_PERIOD_NS;
  localparam int PRES_SMP_FAST_CYC  = PRES_SMP_FAST_NS / CLK_PERIOD_NS;
  localparam int RST_LOW_STD_CYC    = RST_LOW_STD_NS / CLK_PERIOD_NS;
  localparam int RST_LOW_FAST_CYC   = RST_LOW_FAST_NS / CLK_PERIOD_NS;
  localparam int RST_HIGH_STD_CYC   = RST_HIGH_STD_NS / CLK_PERIOD_NS;
  localparam int RST_HIGH_FAST_CYC  = RST_HIGH_FAST_NS / CLK_PERIOD_NS;

  // Width of the reset-cycle and pullup counters.
  localparam int CNT_W = 16;

  // Pointer codes carried by the set-pointer command.
  localparam logic [7:0] PTR_CODE_STATUS = 8'hf0;
  localparam logic [7:0] PTR_CODE_DATA   = 8'he1;
  localparam logic [7:0] PTR_CODE_CONFIG = 8'hc3;

  // Field positions in the settings byte.
  localparam int CFG_SLEW_BIT  = 0;
  localparam int CFG_ZERO_BIT  = 1;
  localparam int CFG_BOOST_BIT = 2;
  localparam int CFG_FAST_BIT  = 3;

  // Reset value of the settings byte and of the reset flag in the status byte.
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic       RST_SEEN_RESET = 1'b1;

  // Field positions in the status byte.
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_PRES_BIT   = 1;
  localparam int ST_SHORT_BIT  = 2;
  localparam int ST_LEVEL_BIT  = 3;
  localparam int ST_RESET_BIT  = 4;
  localparam int ST_SINGLE_BIT = 5;
  localparam int ST_SECOND_BIT = 6;
  localparam int ST_DIR_BIT    = 7;

  // Slot operations handed to the external waveform sequencer.
  typedef enum logic [1:0] {
    OP_SINGLE_BIT = 2'h0,
    OP_WRITE_BYTE = 2'h1,
    OP_READ_BYTE  = 2'h2,
    OP_TRIPLET    = 2'h3
  } slot_op_e;

  // Register selected for reading.
  typedef enum logic [1:0] {
    PTR_STATUS = 2'h0,
    PTR_DATA   = 2'h1,
    PTR_CONFIG = 2'h3
  } read_ptr_e;

  // Bus reset cycle phases; each step flips one bit except high back to idle, which flips both.
  typedef enum logic [1:0] {
    RC_IDLE = 2'h0,
    RC_LOW  = 2'h1,
    RC_HIGH = 2'h3
  } reset_cycle_e;

endpackage

// ---- line_sync.sv ----
// Two-stage synchroniser for asynchronous input levels.
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Level in and synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_ff  <= '1;
      sync_out <= '1;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ---- pullup_timer.sv ----
// One-shot timer that holds the active pullup on for a loaded count.
`timescale 1ns/1ps
`default_nettype none
module pullup_timer
  import wire_master_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Start pulse, cycle count and abort.
  input  wire logic         start_in,
  input  wire logic [W-1:0] len_in,
  input  wire logic         abort_in,
  // High while the timed pullup is on.
  output logic              active_out
);

  logic [W-1:0] cnt_ff;

  // Counts down from the loaded length; abort wins so a reset stops it.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_ff <= '0;
    end else if (abort_in) begin
      cnt_ff <= '0;
    end else if (start_in) begin
      cnt_ff <= len_in;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign active_out = (cnt_ff != '0);

endmodule
`default_nettype wire

// ---- wire_master_cfg_monitor.sv ----
// Checker bound to the settings, status and pullup block.
`timescale 1ns/1ps
`default_nettype none
module wire_master_cfg_monitor (
  // Clock, reset and commands.
  input wire logic       sys_clk_in,
  input wire logic       rstn_in,
  input wire logic       cmd_dev_reset_in,
  input wire logic       cmd_write_cfg_in,
  input wire logic       cmd_bus_reset_in,
  input wire logic       cmd_slot_in,
  input wire logic [7:0] cmd_arg_in,
  // Observed outputs.
  input wire logic [7:0] rd_data_out,
  input wire logic       cmd_refused_out,
  input wire logic       fast_speed_select_out,
  input wire logic       line_low_out,
  input wire logic       pullup_on_out,
  input wire logic       ext_boost_gate_n_out
);
  logic       wr_ok;
  logic       nib_ok;
  logic [7:0] pu_cnt_ff;
  // A write counts only when it is neither refused nor beaten by reset.
  assign wr_ok  = cmd_write_cfg_in & ~cmd_refused_out & ~cmd_dev_reset_in;
  assign nib_ok = cmd_arg_in[7:4] == ~cmd_arg_in[3:0];
  // Length of the running pullup pulse; it wraps in long boosts.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) pu_cnt_ff <= 8'h00;
    else pu_cnt_ff <= pullup_on_out ? pu_cnt_ff + 8'h01 : 8'h00;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  cfg_write_a: assert property (wr_ok && nib_ok |=>
    rd_data_out == {4'h0, $past(cmd_arg_in[3:0]) & 4'hd}
    && fast_speed_select_out == $past(cmd_arg_in[3])) else $error("bad write");
  cfg_reject_a: assert property (wr_ok && !nib_ok |=>
    $stable(fast_speed_select_out)) else $error("bad byte taken");
  high_nibble_a: assert property (wr_ok |=>
    rd_data_out[7:4] == 4'h0) else $error("high nibble set");
  dev_reset_a: assert property (cmd_dev_reset_in |=>
    rd_data_out[7:4] == 4'h1 && rd_data_out[2:0] == 3'h0
    && ext_boost_gate_n_out && !fast_speed_select_out
    && !line_low_out) else $error("device reset incomplete");
  bus_reset_a: assert property (cmd_bus_reset_in && !cmd_refused_out
    && !cmd_dev_reset_in |=> line_low_out && rd_data_out[0]
    && ext_boost_gate_n_out) else $error("bus reset start wrong");
  boost_end_a: assert property (cmd_slot_in && !cmd_refused_out |=>
    ext_boost_gate_n_out) else $error("boost kept over slot");
  gate_boost_a: assert property (!ext_boost_gate_n_out |->
    pullup_on_out) else $error("gate low without pullup");
  pullup_time_a: assert property ($fell(pullup_on_out)
    && $past(ext_boost_gate_n_out) && $past(ext_boost_gate_n_out, 2)
    && !$past(cmd_dev_reset_in) |-> pu_cnt_ff
    == (fast_speed_select_out ? 8'h14 : 8'h64)) else $error("pullup length");
endmodule
bind wire_master_cfg wire_master_cfg_monitor mon (.sys_clk_in, .rstn_in,
  .cmd_dev_reset_in, .cmd_write_cfg_in, .cmd_bus_reset_in, .cmd_slot_in,
  .cmd_arg_in, .rd_data_out, .cmd_refused_out, .fast_speed_select_out,
  .line_low_out, .pullup_on_out, .ext_boost_gate_n_out);
`default_nettype wire

// ---- wire_slave_model.sv ----
// Behavioural slave that answers bus resets with presence or a short.
`timescale 1ns/1ps
`default_nettype none
module wire_slave_model (
  // Clock, line level and speed.
  input wire logic       sys_clk_in,
  input wire logic       line_in,
  input wire logic       fast_in,
  // Answer mode: 0 silent, 1 presence, 2 short.
  input wire logic [1:0] mode_in,
  // Pull-down of the slave.
  output logic           pull_low_out
);
  int low_cnt = 0;
  int t = -1;
  // A low longer than any slot is a reset; own pulses are not counted,
  // so a presence pulse never triggers a second one.
  always @(posedge sys_clk_in) begin
    low_cnt <= (line_in || pull_low_out) ? 0 : low_cnt + 1;
    if (line_in && low_cnt >= 30) t <= 0;
    else if (t >= 0 && t < 6000) t <= t + 1;
    else t <= -1;
  end
  // Presence ends before the shortened high phase so its edge stays in it.
  assign pull_low_out = mode_in == 2'h2 || (mode_in == 2'h1
    && t >= (fast_in ? 80 : 600) && t < (fast_in ? 480 : 2900));
endmodule
`default_nettype wire

// ---- test_wire_master_cfg.sv ----
// Self-checking bench for the settings, status and pullup block.
`timescale 1ns/1ps
`default_nettype none
module test_wire_master_cfg;
  import wire_master_pkg::*;
  logic clk = 0, rstn = 0, dev = 0, ptr = 0, wr = 0, brst = 0, slot = 0;
  logic rd_stb = 0, sq_busy = 0, sq_last = 0, sq_done = 0, h_low = 0;
  logic [1:0] op = 0, mode = 0;
  logic [2:0] sq_res = 0;
  logic [7:0] arg = 0, rd, cfg = 0, b, sq_byte = 0;
  logic ref_o, ref_seen, fast, low, pu, gate_n, s_low;
  int mismatches = 0, checks = 0, n;
  wire logic line;
  assign line = !(low | s_low | h_low);
  always #12.5 clk = ~clk;
  wire_master_cfg #(.RST_LOW_STD(40), .RST_HIGH_STD(3000)) dut (
    .sys_clk_in(clk), .rstn_in(rstn), .cmd_dev_reset_in(dev),
    .cmd_set_ptr_in(ptr), .cmd_write_cfg_in(wr), .cmd_bus_reset_in(brst),
    .cmd_slot_in(slot), .cmd_slot_op_in(op), .cmd_arg_in(arg),
    .rd_strobe_in(rd_stb), .rd_data_out(rd), .cmd_refused_out(ref_o),
    .seq_start_out(), .seq_op_out(), .seq_arg_out(), .seq_abort_out(),
    .fast_speed_select_out(fast), .seq_busy_in(sq_busy),
    .seq_last_slot_in(sq_last), .seq_done_in(sq_done),
    .seq_single_in(sq_res[0]), .seq_second_in(sq_res[1]),
    .seq_dir_in(sq_res[2]), .seq_byte_in(sq_byte),
    .line_in(line), .line_low_out(low), .pullup_on_out(pu),
    .ext_boost_gate_n_out(gate_n));
  wire_slave_model slave (.sys_clk_in(clk), .line_in(line), .fast_in(fast),
    .mode_in(mode), .pull_low_out(s_low));
  // Byte comparison used for every result.
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One command strobe: 0 reset, 1 pointer, 2 settings, 3 bus reset, 4 slot.
  task automatic cmd(int k, logic [7:0] a);
    @(posedge clk);
    {arg, dev, ptr, wr, brst, slot} <= {a, k == 0, k == 1, k == 2, k == 3, k == 4};
    #1 ref_seen = ref_o;
    @(posedge clk);
    {dev, ptr, wr, brst, slot} <= 5'h00;
    #1;
  endtask
  // Host pulls the line low for ten cycles as a slot would.
  task automatic pulse();
    @(posedge clk) h_low <= 1;
    repeat (10) @(posedge clk);
    h_low <= 0;
  endtask
  task automatic slew_run(logic [7:0] v, logic [7:0] exp);
    n = 0;
    cmd(2, v);
    pulse();
    repeat (150) begin @(posedge clk); #1 n += pu; end
    cmp("pullup cycles", exp, 8'(n));
  endtask
  function automatic logic [7:0] cfg_exp(logic [7:0] old, logic [7:0] v);
    return (v[7:4] === ~v[3:0]) ? {4'h0, v[3:0] & 4'hd} : old;
  endfunction
  function automatic logic [7:0] st_exp(logic [1:0] m);
    return m == 2'h1 ? 8'h02 : m == 2'h2 ? 8'h04 : 8'h00;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(32'h2fe9a213));
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    #1 cmp("status", 8'h10, rd);
    cmd(1, PTR_CODE_CONFIG);
    cmp("settings", 8'h00, rd);
    cmd(1, 8'h55);
    cmp("refused", 8'h01, {7'h0, ref_seen});
    cmd(1, PTR_CODE_STATUS);
    @(posedge clk) rd_stb <= 1;
    @(posedge clk) rd_stb <= 0;
    #1 cmp("level", 8'h08, rd & 8'h08);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      b = i == 0 ? 8'h0f : $urandom;
      if (i % 2 == 1) b[7:4] = ~b[3:0];
      cmd(2, b);
      cfg = cfg_exp(cfg, b);
      cmp("settings", cfg, rd);
      cmp("speed", {7'h0, cfg[3]}, {7'h0, fast});
    end
    cmd(1, PTR_CODE_STATUS);
    cmp("reset flag", 8'h00, rd & 8'h10);
    $display("settings test done");
    for (int k = 0; k < 4; k++) begin
      cmd(2, k == 3 ? 8'h69 : 8'he1);
      mode <= k == 1 ? 2'h2 : k == 2 ? 2'h0 : 2'h1;
      cmd(3, 8'h00);
      cmp("busy", 8'h01, rd & 8'h01);
      cmd(2, 8'hf0);
      cmp("refused", 8'h01, {7'h0, ref_seen});
      n = 0;
      for (int i = 0; i < 8000 && rd[0] !== 1'b0; i++) begin
        @(posedge clk);
        #1 n += pu;
      end
      cmp("status", st_exp(mode), rd & 8'h07);
      cmp("pullup", k == 1 ? 8'h00 : k == 3 ? 8'h14 : 8'h64,
          8'(n));
    end
    mode <= 2'h0;
    cmd(2, 8'he1);
    cmd(3, 8'h00);
    repeat (3100) @(posedge clk);
    $display("bus reset test done");
    slew_run(8'he1, 8'h64);
    slew_run(8'h69, 8'h14);
    slew_run(8'hf0, 8'h00);
    $display("pullup test done");
    cmd(2, 8'ha5);
    op <= 2'h1;
    cmd(4, 8'h3c);
    {sq_busy, sq_last} <= 2'h3;
    pulse();
    repeat (20) @(posedge clk);
    #1 cmp("gate", 8'h00, {7'h0, gate_n});
    cmp("boost pullup", 8'h01, {7'h0, pu});
    @(posedge clk) {sq_busy, sq_last, sq_done} <= 3'h1;
    @(posedge clk) sq_done <= 0;
    cmd(1, PTR_CODE_CONFIG);
    cmp("settings", 8'h05, rd);
    op <= 2'h2;
    cmd(4, 8'h00);
    cmp("gate", 8'h01, {7'h0, gate_n});
    cmd(1, PTR_CODE_CONFIG);
    cmp("settings", 8'h01, rd);
    {sq_res, sq_byte} <= 11'($urandom);
    @(posedge clk) sq_done <= 1;
    @(posedge clk) sq_done <= 0;
    cmd(1, PTR_CODE_DATA);
    cmp("read data", sq_byte, rd);
    op <= 2'h3;
    cmd(4, 8'h00);
    @(posedge clk) sq_done <= 1;
    @(posedge clk) sq_done <= 0;
    #1 cmp("results", {sq_res, 5'h00}, rd & 8'he0);
    $display("boost test done");
    cmd(2, 8'h69);
    cmd(0, 8'h00);
    cmp("status", 8'h18, rd);
    cmd(1, PTR_CODE_CONFIG);
    cmp("settings", 8'h00, rd);
    $display("device reset test done");
    test_done();
  end
endmodule
`default_nettype wire
